// File: design/fsg_defines.svh
// Purpose: Constants for the frame sync generator: offsets, fields, timing.
// Assumes: 100 MHz core clock.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
`ifndef FSG_DEFINES_SVH
`define FSG_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define FSG_ADDR_CTL        8'h18
`define FSG_ADDR_HIGH_UPPER 8'h19
`define FSG_ADDR_HIGH_LOWER 8'h1a
`define FSG_ADDR_LOW_UPPER  8'h1b
`define FSG_ADDR_LOW_LOWER  8'h1c

// ****************************************************************
// Control register fields and reset values
// ****************************************************************
`define FSG_CTL_EN_BIT      0
`define FSG_CTL_DUTY_BIT    1
`define FSG_CTL_INIT_BIT    2
`define FSG_CTL_SRC_LSB     4
`define FSG_CTL_SRC_MSB     7
`define FSG_CTL_WMASK       8'hf7
`define FSG_CTL_RESET       8'h00
`define FSG_TIME_RESET      8'h00
`define FSG_SRC_EXT_BIT     3
`define FSG_RATE_50M        3'h6
`define FSG_RATE_W          3

// ****************************************************************
// Tick timing
// ****************************************************************
`define FSG_CLK_PERIOD_NS   10
`define FSG_FRAME_BITS      30
`define FSG_BIT_NS_2M5      400
`define FSG_BIT_NS_50M      20
`define FSG_TICK_CYC_2M5    ((`FSG_FRAME_BITS * `FSG_BIT_NS_2M5) / `FSG_CLK_PERIOD_NS)
`define FSG_TICK_CYC_50M    ((`FSG_FRAME_BITS * `FSG_BIT_NS_50M) / `FSG_CLK_PERIOD_NS)

`endif

// File: design/fsg_pkg.sv
// Purpose: Types shared by the frame sync generator modules.
// Assumes: Constants come from fsg_defines.svh.
// Notes:   All module state travels as packed structs.
package fsg_pkg;

	typedef struct packed
	{
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} fsg_reg_req_t;

	typedef struct packed
	{
		logic [7:0] ctl;
		logic [7:0] high_upper;
		logic [7:0] high_lower;
		logic [7:0] low_upper;
		logic [7:0] low_lower;
	} fsg_regs_t;

endpackage

// File: design/fsg_tick_gen.sv
// Purpose: Generator tick at the back-channel frame period of the chosen port.
// Assumes: Rate code comes from the chosen port's rate setting.
// Notes:   Restart holds the divider so the first tick is a full period away.
`timescale 1ns/1ps
`default_nettype none
`include "fsg_defines.svh"

module fsg_tick_gen
	import fsg_pkg::*;
#(
	parameter int CNT_W = 16
)
(
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       reset_n_i,
	// Control
	input  wire logic       restart_i,
	input  wire logic [2:0] rate_sel_i,
	// Tick
	output var  logic       tick_o
);

	typedef struct packed
	{
		logic [CNT_W-1:0] cnt;
		logic             tick;
	} fsg_tick_state_t;

	localparam logic [CNT_W-1:0] LIMIT_2M5 = CNT_W'(`FSG_TICK_CYC_2M5 - 1);
	localparam logic [CNT_W-1:0] LIMIT_50M = CNT_W'(`FSG_TICK_CYC_50M - 1);

	fsg_tick_state_t s_r;
	fsg_tick_state_t s_nxt;
	logic [CNT_W-1:0] limit;

	// ****************************************************************
	// Divider
	// ****************************************************************
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		limit = (rate_sel_i == `FSG_RATE_50M) ? LIMIT_50M : LIMIT_2M5; // R6 R7 R8
		if (restart_i)
		begin
			s_nxt.cnt = '0;
		end
		else if (s_r.cnt >= limit)
		begin
			s_nxt.cnt = '0;
			s_nxt.tick = 1'b1;
		end
		else
		begin
			s_nxt.cnt = s_r.cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			s_r <= '0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign tick_o = s_r.tick;

endmodule
`default_nettype wire

// File: design/fsg_frame_sync.sv
// Purpose: Frame sync source for the back-channel GPIO lines of four ports.
// Assumes: Register strobes, local GPIO and per-port settings are synchronous.
// Notes:   Each rule below is tagged at the logic that carries it out.
// Function
// R1 - Two sources: external pin or internal generator.
// R2 - External level forwarded to selected ports' lines.
// R3 - All four back channels update together.
// R4 - External when source 0x8-0xF, generator off.
// R5 - Line carries sync only when selected.
// R6 - Tick equals chosen port's frame period.
// R7 - 2.5 Mbps gives 12 us tick.
// R8 - Rate code 110b selects 50 Mbps tick.
// R9 - Enable bit selects generator; runs until disabled.
// R10 - Source field picks tick port; 0 is port0.
// R11 - Mode bit: 0 separate, 1 half duty.
// R12 - Phases last programmed count times tick.
// R13 - Initial-level bit sets starting level.
// R14 - Control and time bytes at 0x18-0x1C.
// R15 - 16-bit tick counter; half duty shares duration.
`timescale 1ns/1ps
`default_nettype none
`include "fsg_defines.svh"

module fsg_frame_sync
	import fsg_pkg::*;
#(
	parameter int PORTS      = 4,
	parameter int LINES      = 4,
	parameter int CNT_W      = 16,
	parameter int LOCAL_GPIO = 8
)
(
	// Clock and reset
	input  wire logic                     core_clk_i,
	input  wire logic                     reset_n_i,
	// Register access
	input  wire fsg_reg_req_t             reg_req_i,
	output var  logic [7:0]               reg_rdata_o,
	output var  logic                     reg_rvalid_o,
	// Local GPIO pins
	input  wire logic [LOCAL_GPIO-1:0]    local_gpio_i,
	// Per-port back-channel settings
	input  wire logic [PORTS*3-1:0]       back_channel_rate_select_i,
	input  wire logic [PORTS*LINES-1:0]   back_channel_gpio_sync_sel_i,
	input  wire logic [PORTS*LINES-1:0]   back_channel_gpio_other_i,
	// Back-channel GPIO lines
	output var  logic [PORTS*LINES-1:0]   back_channel_gpio_line_o,
	output var  logic                     frame_sync_o
);

	localparam int NLINE = PORTS * LINES;
	localparam int SEL_W = $clog2(PORTS);
	localparam int GPW   = $clog2(LOCAL_GPIO);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef enum logic [1:0]
	{
		GEN_ST_OFF = 2'h1,
		GEN_ST_RUN = 2'h2
	} fsg_gen_state_t;

	typedef struct packed
	{
		fsg_regs_t        regs;
		fsg_gen_state_t   gen_state;
		logic             gen_level;
		logic [CNT_W-1:0] gen_cnt;
		logic             sync;
		logic [NLINE-1:0] lines;
		logic [7:0]       rdata;
		logic             rvalid;
	} fsg_state_t;

	fsg_state_t s_r;
	fsg_state_t s_nxt;

	// Decoded control fields.
	logic             gen_en;
	logic             duty_half;
	logic             init_level;
	logic [3:0]       src_sel;
	logic [CNT_W-1:0] high_count;
	logic [CNT_W-1:0] low_count;
	logic [CNT_W-1:0] phase_len;
	logic [CNT_W:0]   cnt_plus;
	logic [SEL_W-1:0] tick_port;
	logic [2:0]       tick_rate;
	logic [`FSG_RATE_W-1:0] port_rate [PORTS];
	logic [7:0]       rd_mux;
	logic             tick;
	logic             ext_mode;
	logic             ext_level;
	logic [NLINE-1:0] lines_d;

	assign gen_en     = s_r.regs.ctl[`FSG_CTL_EN_BIT];
	assign duty_half  = s_r.regs.ctl[`FSG_CTL_DUTY_BIT];
	assign init_level = s_r.regs.ctl[`FSG_CTL_INIT_BIT];
	assign src_sel    = s_r.regs.ctl[`FSG_CTL_SRC_MSB:`FSG_CTL_SRC_LSB];
	assign high_count = {s_r.regs.high_upper, s_r.regs.high_lower}; // R14
	assign low_count  = {s_r.regs.low_upper, s_r.regs.low_lower}; // R14

	// ****************************************************************
	// Tick source
	// ****************************************************************
	// Only the low source bits name a port; higher codes fold onto
	// ports 0 to 3, which keeps every code well defined.
	assign tick_port = src_sel[SEL_W-1:0]; // R10
	genvar pi;
	generate
		for (pi = 0; pi < PORTS; pi++)
		begin : g_port
			assign port_rate[pi] = back_channel_rate_select_i[pi*`FSG_RATE_W +: `FSG_RATE_W]; // R6
		end
	endgenerate

	assign tick_rate = port_rate[tick_port]; // R6

	fsg_tick_gen #(
		.CNT_W      (CNT_W)
	) i_fsg_tick_gen (
		.core_clk_i (core_clk_i),
		.reset_n_i  (reset_n_i),
		.restart_i  (s_r.gen_state != GEN_ST_RUN),
		.rate_sel_i (tick_rate),
		.tick_o     (tick)
	);

	// ****************************************************************
	// Phase length
	// ****************************************************************
	// A zero count would end a phase at the first tick, so it is taken as one tick.
	always_comb
	begin
		if (duty_half || s_r.gen_level)
		begin
			phase_len = high_count; // R11 R15
		end
		else
		begin
			phase_len = low_count; // R12
		end
		if (phase_len == '0)
		begin
			phase_len = CNT_W'(1);
		end
	end

	assign cnt_plus = {1'b0, s_r.gen_cnt} + (CNT_W+1)'(1);

	// ****************************************************************
	// External source
	// ****************************************************************
	// The pin is taken as already synchronous to the core clock; a pin
	// from off the chip needs a synchroniser ahead of this block.
	assign ext_mode  = src_sel[`FSG_SRC_EXT_BIT] && !gen_en; // R4
	assign ext_level = local_gpio_i[src_sel[GPW-1:0]]; // R2

	// ****************************************************************
	// Per-line output select
	// ****************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < NLINE; gi++)
		begin : g_line
			// R5
			assign lines_d[gi] = back_channel_gpio_sync_sel_i[gi] ? s_r.sync
				: back_channel_gpio_other_i[gi];
		end
	endgenerate

	// ****************************************************************
	// Read data
	// ****************************************************************
	// Unmapped offsets answer zero.
	always_comb
	begin
		case (reg_req_i.addr)
			`FSG_ADDR_CTL:
			begin
				rd_mux = s_r.regs.ctl;
			end
			`FSG_ADDR_HIGH_UPPER:
			begin
				rd_mux = s_r.regs.high_upper;
			end
			`FSG_ADDR_HIGH_LOWER:
			begin
				rd_mux = s_r.regs.high_lower;
			end
			`FSG_ADDR_LOW_UPPER:
			begin
				rd_mux = s_r.regs.low_upper;
			end
			`FSG_ADDR_LOW_LOWER:
			begin
				rd_mux = s_r.regs.low_lower;
			end
			default:
			begin
				rd_mux = 8'h00;
			end
		endcase
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.rvalid = 1'b0;

		// Register writes.
		if (reg_req_i.wr)
		begin
			case (reg_req_i.addr) // R14
				`FSG_ADDR_CTL:
				begin
					s_nxt.regs.ctl = reg_req_i.wdata & `FSG_CTL_WMASK;
				end
				`FSG_ADDR_HIGH_UPPER:
				begin
					s_nxt.regs.high_upper = reg_req_i.wdata;
				end
				`FSG_ADDR_HIGH_LOWER:
				begin
					s_nxt.regs.high_lower = reg_req_i.wdata;
				end
				`FSG_ADDR_LOW_UPPER:
				begin
					s_nxt.regs.low_upper = reg_req_i.wdata;
				end
				`FSG_ADDR_LOW_LOWER:
				begin
					s_nxt.regs.low_lower = reg_req_i.wdata;
				end
				default:
				begin
					s_nxt.regs = s_r.regs;
				end
			endcase
		end

		// Register reads return the value held before any write this cycle.
		if (reg_req_i.rd)
		begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata  = rd_mux; // R14
		end

		// Internal generator. Counts are compared live at every tick, so a
		// rewrite of a time value takes effect within the current phase.
		case (s_r.gen_state)
			GEN_ST_OFF:
			begin
				s_nxt.gen_cnt   = '0;
				s_nxt.gen_level = init_level; // R13
				if (gen_en)
				begin
					s_nxt.gen_state = GEN_ST_RUN; // R9
				end
			end
			GEN_ST_RUN:
			begin
				if (!gen_en)
				begin
					s_nxt.gen_state = GEN_ST_OFF;
					s_nxt.gen_cnt   = '0;
					s_nxt.gen_level = init_level; // R13
				end
				else if (tick)
				begin
					if (cnt_plus >= {1'b0, phase_len})
					begin
						s_nxt.gen_cnt   = '0;
						s_nxt.gen_level = !s_r.gen_level; // R12 R15
					end
					else
					begin
						s_nxt.gen_cnt = cnt_plus[CNT_W-1:0]; // R15
					end
				end
			end
			default:
			begin
				// Only an upset can make an illegal code; it parks the generator.
				s_nxt.gen_state = GEN_ST_OFF;
				s_nxt.gen_cnt   = '0;
				s_nxt.gen_level = init_level;
			end
		endcase

		// Source choice; with neither source active the sync rests low.
		if (gen_en)
		begin
			s_nxt.sync = s_nxt.gen_level; // R1 R9
		end
		else if (ext_mode)
		begin
			s_nxt.sync = ext_level; // R1 R2
		end
		else
		begin
			s_nxt.sync = 1'b0;
		end

		// Every line of every port takes its new value on the same edge,
		// so the sync leaves all back channels in the same cycle.
		s_nxt.lines = lines_d; // R3
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			s_r                 <= '0;
			s_r.gen_state       <= GEN_ST_OFF;
			s_r.regs.ctl        <= `FSG_CTL_RESET;
			s_r.regs.high_upper <= `FSG_TIME_RESET;
			s_r.regs.high_lower <= `FSG_TIME_RESET;
			s_r.regs.low_upper  <= `FSG_TIME_RESET;
			s_r.regs.low_lower  <= `FSG_TIME_RESET;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign reg_rdata_o              = s_r.rdata;
	assign reg_rvalid_o             = s_r.rvalid;
	assign back_channel_gpio_line_o = s_r.lines;
	assign frame_sync_o             = s_r.sync;

endmodule
`default_nettype wire

// File: dv/fsg_frame_sync_monitor.sv
// Purpose: Port checker for the frame sync block.
// Assumes: Control is shadowed from the write strobes.
// Notes:   Bound to the design after the module.
`timescale 1ns/1ps
`default_nettype none

// ****
// Checker
// ****
module fsg_frame_sync_monitor
	import fsg_pkg::*;
(
	input  wire logic         core_clk_i,
	input  wire logic         reset_n_i,
	input  wire fsg_reg_req_t reg_req_i,
	input  wire logic [7:0]   reg_rdata_o,
	input  wire logic         reg_rvalid_o,
	input  wire logic [7:0]   local_gpio_i,
	input  wire logic [15:0]  back_channel_gpio_sync_sel_i,
	input  wire logic [15:0]  back_channel_gpio_other_i,
	input  wire logic [15:0]  back_channel_gpio_line_o,
	input  wire logic         frame_sync_o
);
	logic [7:0] ctl_r;
	logic [7:0] a_w;
	assign a_w = reg_req_i.addr;
	// A shadow copy lets the mode checks avoid peeking inside the design.
	always_ff @(posedge core_clk_i or negedge reset_n_i)
		if (!reset_n_i)
			ctl_r <= 8'h00;
		else if (reg_req_i.wr && a_w == 8'h18)
			ctl_r <= reg_req_i.wdata & 8'hf7;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	chk_rvalid_pulse: assert property (reg_req_i.rd |=> reg_rvalid_o)
		else $error("read not answered");
	chk_rvalid_alone: assert property (!reg_req_i.rd |=> !reg_rvalid_o)
		else $error("answer without read");
	chk_unmapped_zero: assert property (reg_req_i.rd && (a_w < 8'h18 || a_w > 8'h1c)
		|=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
	chk_write_readback: assert property (reg_req_i.wr ##2 (reg_req_i.rd && a_w == $past(a_w, 2)
		&& a_w >= 8'h18 && a_w <= 8'h1c) |=> reg_rdata_o == ($past(reg_req_i.wdata, 3)
		& (($past(a_w) == 8'h18) ? 8'hf7 : 8'hff))) else $error("readback wrong");
	chk_ext_follow: assert property (!ctl_r[0] && ctl_r[7]
		|=> frame_sync_o == $past(local_gpio_i[ctl_r[6:4]])) else $error("pin not followed");
	chk_off_low: assert property (!ctl_r[0] && !ctl_r[7] |=> !frame_sync_o)
		else $error("sync high with no source");
	chk_line_sync: assert property (((back_channel_gpio_line_o ^ {16{$past(frame_sync_o)}})
		& $past(back_channel_gpio_sync_sel_i)) == 16'h0000) else $error("line lost sync");
	chk_line_other: assert property (((back_channel_gpio_line_o
		^ $past(back_channel_gpio_other_i)) & ~$past(back_channel_gpio_sync_sel_i)) == 16'h0000)
		else $error("unselected line wrong");
	chk_gen_hold: assert property ($changed(frame_sync_o) && ctl_r[0] && $past(ctl_r[0])
		|=> $stable(frame_sync_o) [*8]) else $error("phase shorter than a tick");
endmodule

bind fsg_frame_sync fsg_frame_sync_monitor i_fsg_frame_sync_monitor (.core_clk_i, .reset_n_i,
	.reg_req_i, .reg_rdata_o, .reg_rvalid_o, .local_gpio_i, .back_channel_gpio_sync_sel_i,
	.back_channel_gpio_other_i, .back_channel_gpio_line_o, .frame_sync_o);
`default_nettype wire

// File: dv/fsg_serializer_model.sv
// Purpose: Far-side serializers receiving the back-channel lines.
// Assumes: One flop of link delay, the same for every port.
// Notes:   Equal delay on all ports keeps the skew check meaningful.
`timescale 1ns/1ps
`default_nettype none

// ****
// Model
// ****
module fsg_serializer_model
(
	input  wire logic        core_clk_i,
	input  wire logic [15:0] line_i,
	output var  logic [15:0] rx_o
);
	always_ff @(posedge core_clk_i)
		rx_o <= line_i;
endmodule
`default_nettype wire

// File: dv/fsg_frame_sync_tb.sv
// Purpose: Self-checking bench for the frame sync block.
// Assumes: Register port takes one-cycle write and read strobes.
// Notes:   Phases are measured between output edges.
`timescale 1ns/1ps
`default_nettype none

// ****
// Bench
// ****
module fsg_frame_sync_tb
	import fsg_pkg::*;
;
	logic         core_clk_i;
	logic         reset_n_i;
	fsg_reg_req_t req;
	logic [7:0]   rdata;
	logic         rvalid;
	logic [7:0]   gpio;
	logic [11:0]  rate;
	logic [15:0]  sel;
	logic [15:0]  other;
	logic [15:0]  line;
	logic [15:0]  rx;
	logic         fs;
	int           err_count;
	int           tests_run;

	fsg_frame_sync i_fsg_frame_sync (.core_clk_i, .reset_n_i, .reg_req_i(req),
		.reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .local_gpio_i(gpio),
		.back_channel_rate_select_i(rate), .back_channel_gpio_sync_sel_i(sel),
		.back_channel_gpio_other_i(other), .back_channel_gpio_line_o(line), .frame_sync_o(fs));
	fsg_serializer_model i_fsg_serializer_model (.core_clk_i, .line_i(line), .rx_o(rx));

	initial
	begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end

	task automatic report_and_stop();
		if (err_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_i) req <= '{1'b1, 1'b0, a, d};
		@(posedge core_clk_i) req <= '0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk_i) req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge core_clk_i) req <= '0;
		#1 cmp({15'h0000, rvalid}, 16'h0001);
		cmp({8'h00, rdata}, {8'h00, exp});
	endtask

	task automatic wait_fs(input logic lvl, inout int n);
		while (fs !== lvl)
		begin
			@(posedge core_clk_i);
			#1 n++;
			if (n > 8000)
			begin
				err_count++;
				report_and_stop();
			end
		end
	endtask

	// The first phase after enable is skipped: it includes the divider start-up.
	task automatic phase(input logic lvl, input int exp);
		int n;
		n = 0;
		wait_fs(~lvl, n);
		wait_fs(lvl, n);
		n = 0;
		wait_fs(~lvl, n);
		cmp(16'(n), 16'(exp));
		repeat (10) @(posedge core_clk_i);
	endtask

	task automatic t_regs();
		for (int i = 0; i < 5; i++)
			rd(8'h18 + 8'(i), 8'h00);
		for (int i = 0; i < 5; i++)
		begin
			wr(8'h18 + 8'(i), 8'hff - 8'(i));
			rd(8'h18 + 8'(i), (i == 0) ? 8'hf7 : 8'hff - 8'(i));
		end
		wr(8'h20, 8'h55);
		rd(8'h20, 8'h00);
	endtask

	task automatic t_ext();
		for (int g = 0; g < 8; g++)
		begin
			wr(8'h18, {4'(8 + g), 4'h0});
			for (int v = 0; v < 2; v++)
			begin
				@(posedge core_clk_i) gpio <= v[0] ? 8'(1 << g) : ~8'(1 << g);
				repeat (3) @(posedge core_clk_i);
				#1 cmp({15'h0000, fs}, {15'h0000, v[0]});
				cmp(rx, (sel & {16{v[0]}}) | (~sel & other));
			end
		end
	endtask

	task automatic t_gen(input logic [7:0] c, input logic [11:0] r, input int hi, input int lo);
		int t;
		t = (r[3 * int'(c[5:4]) +: 3] == 3'h6) ? 60 : 1200;
		@(posedge core_clk_i) rate <= r;
		wr(8'h19, 8'h00);
		wr(8'h1a, 8'(hi));
		wr(8'h1b, 8'h00);
		wr(8'h1c, 8'(lo));
		wr(8'h18, c);
		repeat (3) @(posedge core_clk_i);
		#1 cmp({15'h0000, fs}, {15'h0000, c[2]});
		phase(1'b1, hi * t);
		phase(1'b0, (c[1] ? hi : lo) * t);
		wr(8'h18, 8'h00);
		repeat (3) @(posedge core_clk_i);
		#1 cmp({15'h0000, fs}, 16'h0000);
	endtask

	initial
	begin
		reset_n_i = 1'b0;
		req = '0;
		gpio = 8'h00;
		rate = 12'h000;
		sel = 16'h5555;
		other = 16'h0000;
		err_count = 0;
		tests_run = 0;
		repeat (16) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		@(posedge core_clk_i) other <= 16'haaaa;
		t_regs();
		t_ext();
		t_gen(8'h01, 12'h006, 3, 2);
		t_gen(8'h07, 12'h006, 3, 2);
		t_gen(8'h11, 12'h006, 1, 2);
		report_and_stop();
	end
endmodule
`default_nettype wire
